// File: rtl/uem_ep0_mode.sv
// endpoint-zero mode, status and count registers with engine interlock
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module uem_ep0_mode
  import uem_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire uem_evt_s engEvt,
  input wire uem_engwr_s engWr,
  output logic [3:0] epMode,
  output logic [7:0] epCount,
  output logic [3:0] epFlags,
  output logic fifoWriteBlock,
  output logic modeLocked,
  output logic countLocked
);

  if (ADDR_W < 11) begin : g_bad_addr
    $error("uem_ep0_mode: ADDR_W must be at least 11");
  end

  // write channel holding and read channel response
  logic awHeld;
  logic [ADDR_W-1:0] awAddr;
  logic wHeld;
  logic [7:0] wData;
  logic wLane0;
  logic bvalid;
  logic [1:0] bresp;
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;

  // register state
  logic [3:0] modeField;
  logic [3:0] flags;
  logic [7:0] count;
  logic modeLock;
  logic countLock;

  logic [3:0] next_mode;
  logic [3:0] next_flags;
  logic [7:0] next_count;
  logic next_modeLock;
  logic next_countLock;

  wire logic awTake = s_axi_awvalid && s_axi_awready;
  wire logic wTake = s_axi_wvalid && s_axi_wready;
  wire logic arTake = s_axi_arvalid && s_axi_arready;

  // the write is carried out once both halves sit in the holding flops
  wire logic doWrite = awHeld && wHeld && !bvalid;

  wire logic wrHighZero = awAddr[ADDR_W-1:10] == '0;
  wire logic wrLowZero = awAddr[1:0] == 2'h0;
  wire logic wrHitMode = wrHighZero && wrLowZero && (awAddr[9:2] == MODE_IDX);
  wire logic wrHitCount = wrHighZero && wrLowZero && (awAddr[9:2] == COUNT_IDX);
  wire logic wrMapped = wrHitMode || wrHitCount;

  wire logic rdHighZero = s_axi_araddr[ADDR_W-1:10] == '0;
  wire logic rdLowZero = s_axi_araddr[1:0] == 2'h0;
  wire logic rdHitMode = rdHighZero && rdLowZero && (s_axi_araddr[9:2] == MODE_IDX);
  wire logic rdHitCount = rdHighZero && rdLowZero && (s_axi_araddr[9:2] == COUNT_IDX);
  wire logic rdMapped = rdHitMode || rdHitCount;

  // processor reads that release a lock
  wire logic cpuRdMode = arTake && rdHitMode;
  wire logic cpuRdCount = arTake && rdHitCount;

  // processor writes that pass the interlock; lane 0 carries the byte
  wire logic cpuModeWr = doWrite && wrHitMode && wLane0 && !modeLock;
  wire logic cpuCountWr = doWrite && wrHitCount && wLane0 && !countLock;

  wire logic anyEvt = engEvt.setupRcv || engEvt.inAck || engEvt.outRcv || engEvt.ackTrans;
  wire logic engModeTouch = engWr.modeWr || anyEvt;

  wire logic [3:0] evtVec = {engEvt.setupRcv, engEvt.inAck, engEvt.outRcv, engEvt.ackTrans};

  wire logic [31:0] rdValue = rdHitMode ? {24'h000000, flags, modeField} :
                              rdHitCount ? {24'h000000, count} : 32'h00000000;

  assign s_axi_awready = !awHeld && !bvalid;
  assign s_axi_wready = !wHeld && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  // event flags: an event in the same cycle as a clearing write wins
  for (genvar i = 0; i < FLAG_W; i++) begin : g_flag
    assign next_flags[i] = evtVec[i] ? 1'b1 : (cpuModeWr ? 1'b0 : flags[i]);
  end

  // engine writes take precedence over the processor in the same cycle
  assign next_mode = engWr.modeWr ? engWr.modeData :
                     (cpuModeWr ? wData[3:0] : modeField);
  assign next_count = engWr.countWr ? engWr.countData :
                      (cpuCountWr ? wData : count);

  // a lock set and a releasing read in one cycle leaves it locked
  assign next_modeLock = engModeTouch ? 1'b1 : (cpuRdMode ? 1'b0 : modeLock);
  assign next_countLock = engWr.countWr ? 1'b1 : (cpuRdCount ? 1'b0 : countLock);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      modeField <= MODE_RST;
      flags <= FLAG_RST;
      count <= COUNT_RST;
      modeLock <= 1'b0;
      countLock <= 1'b0;
    end else begin
      modeField <= next_mode;
      flags <= next_flags;
      count <= next_count;
      modeLock <= next_modeLock;
      countLock <= next_countLock;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeld <= 1'b0;
      awAddr <= '0;
    end else if (awTake) begin
      awHeld <= 1'b1;
      awAddr <= s_axi_awaddr;
    end else if (doWrite) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wHeld <= 1'b0;
      wData <= 8'h00;
      wLane0 <= 1'b0;
    end else if (wTake) begin
      wHeld <= 1'b1;
      wData <= s_axi_wdata[7:0];
      wLane0 <= s_axi_wstrb[0];
    end else if (doWrite) begin
      wHeld <= 1'b0;
    end
  end

  // a locked write still answers okay; software sees the ignore only on readback
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else if (arTake) begin
      rvalid <= 1'b1;
      rdata <= rdValue;
      rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid <= 1'b0;
    end
  end

  assign epMode = modeField;
  assign epCount = count;
  assign epFlags = flags;
  assign fifoWriteBlock = flags[FLAG_SETUP];
  assign modeLocked = modeLock;
  assign countLocked = countLock;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence sModeWrLocked;
    doWrite && wrHitMode && wLane0 && modeLock && !engModeTouch;
  endsequence

  sequence sCountWrLocked;
    doWrite && wrHitCount && wLane0 && countLock && !engWr.countWr;
  endsequence

  sequence sModeCleanWr;
    cpuModeWr && !anyEvt && !engWr.modeWr;
  endsequence

  sequence sModeReadTaken;
    arTake && rdHitMode;
  endsequence

  a_count_lock_guard:
  assert property (sCountWrLocked |=> count == $past(count))
    else $error("locked count register changed on processor write");

  a_mode_lock_guard:
  assert property (sModeWrLocked |=> modeField == $past(modeField) && flags == $past(flags))
    else $error("locked mode register changed on processor write");

  a_engine_locks:
  assert property (engModeTouch |=> modeLock ##0 modeLocked)
    else $error("engine write did not lock mode register");

  a_count_engine_lock:
  assert property (engWr.countWr |=> countLock && count == $past(engWr.countData))
    else $error("engine count write did not load and lock");

  a_lock_until_read:
  assert property (modeLock && !cpuRdMode |=> modeLock)
    else $error("mode lock released without a read");

  a_read_releases:
  assert property (sModeReadTaken ##0 !engModeTouch |=> !modeLock)
    else $error("mode lock kept after processor read");

  a_write_clears_flags:
  assert property (sModeCleanWr |=> flags == 4'h0 && modeField == $past(wData[3:0]))
    else $error("mode write did not clear flags or load mode");

  a_mode_readback:
  assert property (sModeReadTaken |=> rvalid && rdata[7:0] == $past({flags, modeField}) && rdata[31:8] == 24'h0)
    else $error("mode register readback wrong");

  a_setup_blocks_fifo:
  assert property (engEvt.setupRcv |=> fifoWriteBlock ##1 (fifoWriteBlock || $past(cpuModeWr)))
    else $error("setup event did not block fifo writes");

  a_event_over_clear:
  assert property (cpuModeWr && engEvt.inAck |=> flags[FLAG_IN])
    else $error("in event lost against a clearing write");

  a_write_answer:
  assert property (doWrite |=> bvalid && bresp == ($past(wrMapped) ? RESP_OKAY : RESP_SLVERR))
    else $error("write response missing or wrong");

endmodule // uem_ep0_mode

// File: rtl/uem_pkg.sv
// constants and types for the endpoint-zero mode and status block
// Overview of operation
// - one lock scheme guards both the endpoint-zero mode register and the endpoint-zero count register.
// - any write by the usb protocol engine to the mode or count register locks that register.
// - processor writes to a locked register are ignored until the processor reads that register.
// - any accepted processor write to the mode register clears its four event flags, whatever the data, except a flag whose event arrives in the same cycle.
// - the mode register sits at index 0x44 with mode in bits 3:0 and event flags in bits 7:4, reset to zero.
package uem_pkg;

  // printed offsets are register indexes; byte address is four times the index
  localparam logic [7:0] MODE_IDX = 8'h44;
  localparam logic [7:0] COUNT_IDX = 8'h41;

  localparam int MODE_LSB = 0;
  localparam int MODE_W = 4;
  localparam int FLAG_LSB = 4;
  localparam int FLAG_W = 4;
  localparam int FLAG_SETUP = 3;
  localparam int FLAG_IN = 2;
  localparam int FLAG_OUT = 1;
  localparam int FLAG_ACK = 0;

  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [3:0] FLAG_RST = 4'h0;
  localparam logic [7:0] COUNT_RST = 8'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // one-cycle completion pulses from the protocol engine
  typedef struct packed {
    logic setupRcv;
    logic inAck;
    logic outRcv;
    logic ackTrans;
  } uem_evt_s;

  // an engine write into a register
  typedef struct packed {
    logic modeWr;
    logic [3:0] modeData;
    logic countWr;
    logic [7:0] countData;
  } uem_engwr_s;

endpackage

// File: testbench/tb.sv
// self-checking bench for the endpoint-zero mode block
`timescale 1ns/1ps
module tb
  import uem_pkg::*;
;
  localparam logic [11:0] MODE_A = {2'b00, MODE_IDX, 2'b00};
  localparam logic [11:0] CNT_A = {2'b00, COUNT_IDX, 2'b00};
  logic sys_clk = 1'b0, rst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic fifoWriteBlock, modeLocked, countLocked;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hf, epMode, epFlags;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdData;
  logic [1:0] s_axi_bresp, s_axi_rresp, rdResp;
  logic [7:0] epCount;
  uem_evt_s engEvt;
  uem_engwr_s engWr;
  int miscompares = 0;
  int check_count = 0;

  uem_ep0_mode dut_u (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(s_axi_awprot),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(s_axi_arprot),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .engEvt(engEvt),
    .engWr(engWr),
    .epMode(epMode),
    .epCount(epCount),
    .epFlags(epFlags),
    .fifoWriteBlock(fifoWriteBlock),
    .modeLocked(modeLocked),
    .countLocked(countLocked)
  );
  uem_eng_model eng_u (.sys_clk(sys_clk), .engEvt(engEvt), .engWr(engWr));

  always #2 sys_clk = ~sys_clk;

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask

  // handshakes sampled at the falling edge, acted on at the next rising edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic aw, w, b;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge sys_clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      if (b)
        chk("bresp", {30'h0, RESP_OKAY}, {30'h0, s_axi_bresp});
      @(posedge sys_clk);
      if (aw)
        s_axi_awvalid <= 1'b0;
      if (w)
        s_axi_wvalid <= 1'b0;
      if (b) begin
        s_axi_bready <= 1'b0;
        return;
      end
    end
    miscompares++;
    wrap_up();
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, v;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge sys_clk);
      ar = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk);
      if (ar)
        s_axi_arvalid <= 1'b0;
      if (v) begin
        s_axi_rready <= 1'b0;
        return;
      end
    end
    miscompares++;
    wrap_up();
  endtask

  task automatic rdChk(input string nm, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(nm, e, d);
    chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdChk("modeRst", MODE_A, 32'h0);
    rdChk("countRst", CNT_A, 32'h0);
    rd(12'h200, rdData, rdResp);
    chk("unmapResp", {30'h0, RESP_SLVERR}, {30'h0, rdResp});
    wr(MODE_A, 8'hf5);
    rdChk("modeWr", MODE_A, 32'h05);
    // each event locks, survives a blind write, then clears on a write after a read
    for (int i = 0; i < 4; i++) begin
      eng_u.strobe(uem_evt_s'(4'h1 << i), '0);
      @(negedge sys_clk);
      chk("modeLocked", 32'h1, {31'h0, modeLocked});
      chk("epFlags", 32'h1 << i, {28'h0, epFlags});
      chk("fifoBlock", {31'h0, i == FLAG_SETUP}, {31'h0, fifoWriteBlock});
      wr(MODE_A, 8'h0a);
      rdChk("flagSet", MODE_A, 32'h05 | (32'h10 << i));
      wr(MODE_A, 8'hf5);
      rdChk("flagClr", MODE_A, 32'h05);
    end
    chk("fifoFree", 32'h0, {31'h0, fifoWriteBlock});
    eng_u.strobe('0, '{1'b1, 4'h3, 1'b0, 8'h00});
    wr(MODE_A, 8'h0c);
    rdChk("engMode", MODE_A, 32'h03);
    chk("epMode", 32'h3, {28'h0, epMode});
    eng_u.strobe('0, '{1'b0, 4'h0, 1'b1, 8'h33});
    @(negedge sys_clk);
    chk("countLocked", 32'h1, {31'h0, countLocked});
    wr(CNT_A, 8'h77);
    rdChk("engCount", CNT_A, 32'h33);
    wr(CNT_A, 8'h77);
    rdChk("cpuCount", CNT_A, 32'h77);
    chk("epCount", 32'h77, {24'h0, epCount});
    // in event lands on the same edge as an unlocked clearing write: the set wins
    fork
      begin
        wr(MODE_A, 8'h05);
      end
      begin
        @(posedge sys_clk);
        eng_u.strobe(uem_evt_s'(4'h4), '0);
      end
    join
    @(negedge sys_clk);
    chk("evtOverClr", 32'h4, {28'h0, epFlags});
    chk("evtLock", 32'h1, {31'h0, modeLocked});
    rdChk("evtWin", MODE_A, 32'h45);
    // a write without byte lane 0 must leave mode and flags alone
    s_axi_wstrb <= 4'h0;
    wr(MODE_A, 8'h0a);
    s_axi_wstrb <= 4'hf;
    rdChk("noLane", MODE_A, 32'h45);
    chk("epModeEnd", 32'h5, {28'h0, epMode});
    wrap_up();
  end
endmodule // tb

// File: testbench/uem_eng_model.sv
// protocol engine stand-in driving event and write strobes
`timescale 1ns/1ps
module uem_eng_model
  import uem_pkg::*;
(
  input wire logic sys_clk,
  output uem_evt_s engEvt,
  output uem_engwr_s engWr
);
  initial begin
    engEvt = '0;
    engWr = '0;
  end
  // strobes last one cycle, as the engine pulses them
  task automatic strobe(input uem_evt_s e, input uem_engwr_s w);
    @(posedge sys_clk);
    engEvt <= e;
    engWr <= w;
    @(posedge sys_clk);
    engEvt <= '0;
    engWr <= '0;
  endtask
endmodule // uem_eng_model
